//--- cpu_core_model.sv
// Behavioural model of the CPU core side: acknowledges the granted source.
// Assumes the block's registered request and a one-cycle acknowledge pulse.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire irq_ctl_pkg::cpu_req_t req_in,
	input  wire logic                  enable_in,
	input  wire logic                  slow_in,
	output logic                       ack_out,
	output logic [3:0]                 ack_id_out
);
	int cnt;
	int dly;

	// Slow mode stands for a long instruction finishing before acceptance
	assign dly = slow_in ? 6 : 1;

	// Count while a request stands; after an ack, wait out the flag clear before retrying
	always_ff @(posedge clk_in) begin
		if (rst_in || !enable_in || (req_in.valid !== 1'b1 && cnt <= dly)) begin
			cnt <= 0;
		end else if (cnt == dly + 4) begin
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
		ack_out <= !rst_in && enable_in && req_in.valid === 1'b1 && cnt == dly;
		ack_id_out <= req_in.id;
	end
endmodule
`default_nettype wire

//--- irq_ctl.sv
// Interrupt priority, enable and external pin detection block.
// Assumes an APB master on ref_clk_in, async pins, same-clock source lines.
//
// The APB register port is this design's own decision.
`include "irq_ctl_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module irq_ctl (
	input  wire logic                 ref_clk_in,
	input  wire logic                 sys_rst_in,
	input  wire logic                 clk_en_in,
	input  wire irq_ctl_pkg::apb_req_t apb_in,
	output logic                      pready_out,
	output logic                      pslverr_out,
	output logic [31:0]               prdata_out,
	input  wire logic [1:0]           ext_pin_in,
	input  wire logic [7:0]           port1_pin_in,
	input  wire logic [15:0]          src_req_in,
	input  wire logic                 ack_in,
	input  wire logic [3:0]           ack_id_in,
	output irq_ctl_pkg::cpu_req_t     cpu_req_out,
	output logic                      irq_out
);

	// Two-bit level of source n
	function automatic logic [1:0] prio_of(input logic [15:0] hi,
		input logic [15:0] lo, input int n);
		prio_of = {hi[n], lo[n]};
	endfunction

	// Detection of one external pin
	function automatic logic detect(input logic en, input logic dual,
		input logic edg, input logic pol, input logic cur, input logic prv);
		logic rise;
		logic fall;
		rise = cur & ~prv;
		fall = ~cur & prv;
		if (!en)
			detect = 1'b0;
		else if (dual)
			detect = rise | fall;
		else if (edg)
			detect = pol ? fall : rise;
		else
			detect = pol ? ~cur : cur;
	endfunction

	irq_ctl_pkg::regs_t    regs_r;
	irq_ctl_pkg::regs_t    regs_nxt;
	irq_ctl_pkg::apb_rsp_t rsp_r;
	irq_ctl_pkg::apb_rsp_t rsp_nxt;
	irq_ctl_pkg::cpu_req_t req_r;
	irq_ctl_pkg::cpu_req_t req_nxt;
	logic [1:0]  ext_s1_r;
	logic [1:0]  ext_s2_r;
	logic [1:0]  ext_prev_r;
	logic [7:0]  p1_s1_r;
	logic [7:0]  p1_s2_r;
	logic [7:0]  p1_prev_r;
	logic [1:0]  ext_s1_nxt;
	logic [1:0]  ext_s2_nxt;
	logic [1:0]  ext_prev_nxt;
	logic [7:0]  p1_s1_nxt;
	logic [7:0]  p1_s2_nxt;
	logic [7:0]  p1_prev_nxt;
	logic [1:0]  ext_ev;
	logic        pc_ev;
	logic [7:0]  ev_vec;
	logic [7:0]  ack_vec;
	logic [9:0]  idx;
	logic        setup_done;
	logic        xfer;
	logic        wr;
	logic        mapped;
	logic [7:0]  rd_byte;
	logic [7:0]  wdat;
	logic [15:0] pend;
	logic [15:0] en16;
	logic [15:0] elig;
	logic [15:0] lo16;
	logic [15:0] hi16;

	assign idx  = apb_in.paddr[11:2];
	assign wdat = apb_in.pwdata[7:0];
	// Access phase not yet answered
	assign setup_done = apb_in.psel & apb_in.penable & ~rsp_r.pready;
	// Completing edge of a transfer
	assign xfer = apb_in.psel & apb_in.penable & rsp_r.pready;
	assign wr   = xfer & apb_in.pwrite;

	// Pin synchronisers; first stage feeds only the second
	always_comb begin
		ext_s1_nxt   = ext_pin_in;
		ext_s2_nxt   = ext_s1_r;
		ext_prev_nxt = ext_s2_r;
		p1_s1_nxt    = port1_pin_in;
		p1_s2_nxt    = p1_s1_r;
		p1_prev_nxt  = p1_s2_r;
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			ext_s1_r   <= 2'h0;
			ext_s2_r   <= 2'h0;
			ext_prev_r <= 2'h0;
			p1_s1_r    <= 8'h00;
			p1_s2_r    <= 8'h00;
			p1_prev_r  <= 8'h00;
		end else if (clk_en_in) begin
			ext_s1_r   <= ext_s1_nxt;
			ext_s2_r   <= ext_s2_nxt;
			ext_prev_r <= ext_prev_nxt;
			p1_s1_r    <= p1_s1_nxt;
			p1_s2_r    <= p1_s2_nxt;
			p1_prev_r  <= p1_prev_nxt;
		end
	end

	// Event detection per pin
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			ext_ev[i] = detect(regs_r.ext_pin_enable[i],
				regs_r.ext_dual_edge_enable[i],
				regs_r.ext_edge_select[i],
				regs_r.ext_polarity_select[i],
				ext_s2_r[i], ext_prev_r[i]);
		end
		// Any enabled port-one change
		pc_ev = |(regs_r.pin_change_enable & (p1_s2_r ^ p1_prev_r));
		ev_vec = 8'h00;
		ev_vec[`FLG_EXT0] = ext_ev[0];
		ev_vec[`FLG_EXT1] = ext_ev[1];
		ev_vec[`FLG_PCI]  = pc_ev;
	end

	// Service acknowledge clears the matching flag
	always_comb begin
		ack_vec = 8'h00;
		if (ack_in && ack_id_in[3:2] == 2'h0)
			ack_vec[ack_id_in[1:0]] = 1'b1;
		ack_vec = ack_vec & `MSK_FLAGS;
	end

	// Address decode and read mux
	always_comb begin
		mapped  = 1'b1;
		rd_byte = 8'h00;
		unique case (idx)
			`IDX_PRIO_LO0:  rd_byte = regs_r.prio_low_group0;
			`IDX_PRIO_HI0:  rd_byte = regs_r.prio_high_group0;
			`IDX_PRIO_LO1:  rd_byte = regs_r.prio_low_group1;
			`IDX_PRIO_HI1:  rd_byte = regs_r.prio_high_group1;
			`IDX_PRIO_LO2:  rd_byte = regs_r.prio_low_group2;
			`IDX_PRIO_HI2:  rd_byte = regs_r.prio_high_group2;
			`IDX_PIN_CHG:   rd_byte = regs_r.pin_change_enable;
			`IDX_EXT_EN:    rd_byte = regs_r.ext_pin_enable;
			`IDX_EXT_FLAGS: rd_byte = regs_r.ext_pending_flags;
			`IDX_EXT_EDGE:  rd_byte = regs_r.ext_edge_select;
			`IDX_EXT_POL:   rd_byte = regs_r.ext_polarity_select;
			`IDX_EXT_DUAL:  rd_byte = regs_r.ext_dual_edge_enable;
			`IDX_IE_FIRST:  rd_byte = regs_r.irq_enable_first;
			`IDX_IE_SECOND: rd_byte = regs_r.irq_enable_second;
			`IDX_IE_THIRD:  rd_byte = regs_r.irq_enable_third;
			`IDX_EVT_STAT:  rd_byte = regs_r.evt_status;
			`IDX_EVT_MASK:  rd_byte = regs_r.evt_mask;
			default:        mapped  = 1'b0;
		endcase
	end

	// APB answer: one wait state, read data sampled in it
	always_comb begin
		rsp_nxt.pready  = setup_done;
		rsp_nxt.pslverr = setup_done & ~mapped;
		rsp_nxt.prdata  = setup_done ? {24'h000000, rd_byte} : 32'h00000000;
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			rsp_r <= {1'b0, 1'b0, 32'h00000000};
		end else if (clk_en_in) begin
			rsp_r <= rsp_nxt;
		end
	end

	assign pready_out  = rsp_r.pready;
	assign pslverr_out = rsp_r.pslverr;
	assign prdata_out  = rsp_r.prdata;

	// Register writes, flag set/clear; hardware set beats any clear
	always_comb begin
		regs_nxt = regs_r;
		if (wr) begin
			unique case (idx)
				`IDX_PRIO_LO0:  regs_nxt.prio_low_group0 = wdat & `MSK_PRIO6;
				`IDX_PRIO_HI0:  regs_nxt.prio_high_group0 = wdat & `MSK_PRIO6;
				`IDX_PRIO_LO1:  regs_nxt.prio_low_group1 = wdat & `MSK_PRIO6;
				`IDX_PRIO_HI1:  regs_nxt.prio_high_group1 = wdat & `MSK_PRIO6;
				`IDX_PRIO_LO2:  regs_nxt.prio_low_group2 = wdat & `MSK_PRIO4;
				`IDX_PRIO_HI2:  regs_nxt.prio_high_group2 = wdat & `MSK_PRIO4;
				`IDX_PIN_CHG:   regs_nxt.pin_change_enable = wdat & `MSK_PIN_CHG;
				`IDX_EXT_EN:    regs_nxt.ext_pin_enable = wdat & `MSK_EXT2;
				`IDX_EXT_EDGE:  regs_nxt.ext_edge_select = wdat & `MSK_EXT2;
				`IDX_EXT_POL:   regs_nxt.ext_polarity_select = wdat & `MSK_EXT2;
				`IDX_EXT_DUAL:  regs_nxt.ext_dual_edge_enable = wdat & `MSK_EXT2;
				`IDX_IE_FIRST:  regs_nxt.irq_enable_first = wdat & `MSK_IE_FIRST;
				`IDX_IE_SECOND: regs_nxt.irq_enable_second = wdat & `MSK_IE_SECOND;
				`IDX_IE_THIRD:  regs_nxt.irq_enable_third = wdat & `MSK_IE_THIRD;
				`IDX_EVT_MASK:  regs_nxt.evt_mask = wdat & `MSK_FLAGS;
				// Writing a one never sets a pending flag
				`IDX_EXT_FLAGS: regs_nxt.ext_pending_flags = regs_r.ext_pending_flags & wdat;
				// Status clears by writing ones
				`IDX_EVT_STAT:  regs_nxt.evt_status = regs_r.evt_status & ~wdat;
				default:        regs_nxt = regs_r;
			endcase
		end
		regs_nxt.ext_pending_flags = (regs_nxt.ext_pending_flags & ~ack_vec) | ev_vec;
		regs_nxt.evt_status = regs_nxt.evt_status | ev_vec;
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			regs_r <= {17{`RST_BYTE}};
		end else if (clk_en_in) begin
			regs_r <= regs_nxt;
		end
	end

	// Masked sticky events onto one level line
	assign irq_out = |(regs_r.evt_status & regs_r.evt_mask);

	// Request, enable and level vectors
	always_comb begin
		pend = src_req_in;
		pend[`FLG_EXT0] = regs_r.ext_pending_flags[`FLG_EXT0];
		pend[`FLG_EXT1] = regs_r.ext_pending_flags[`FLG_EXT1];
		pend[`FLG_PCI]  = regs_r.ext_pending_flags[`FLG_PCI];
		pend[2]  = 1'b0;
		pend[5]  = 1'b0;
		// Reserved slots are masked by the enable registers
		en16 = {regs_r.irq_enable_third[3:0], regs_r.irq_enable_second[5:0],
			regs_r.irq_enable_first[5:0]};
		elig = en16 & pend & {16{regs_r.irq_enable_first[`GIE_BIT]}};
		lo16 = {regs_r.prio_low_group2[3:0], regs_r.prio_low_group1[5:0],
			regs_r.prio_low_group0[5:0]};
		hi16 = {regs_r.prio_high_group2[3:0], regs_r.prio_high_group1[5:0],
			regs_r.prio_high_group0[5:0]};
	end

	// Winner search; scanning downward with >= lets low numbers win ties
	always_comb begin
		req_nxt = {1'b0, 4'h0, 2'h0};
		for (int n = 15; n >= 0; n--) begin
			if (elig[n] && (!req_nxt.valid || prio_of(hi16, lo16, n) >= req_nxt.level)) begin
				req_nxt.valid = 1'b1;
				req_nxt.id    = 4'(n);
				req_nxt.level = prio_of(hi16, lo16, n);
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			req_r <= {1'b0, 4'h0, 2'h0};
		end else if (clk_en_in) begin
			req_r <= req_nxt;
		end
	end

	assign cpu_req_out = req_r;

	// Checks
	a_apb_wait_one: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && setup_done |=> pready_out)
		else $error("pready not raised after one wait state");

	a_pin_event_flag: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && ext_ev[0] |=> regs_r.ext_pending_flags[`FLG_EXT0])
		else $error("pin 0 event did not set its flag");

	a_flag_write_clr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && wr && idx == `IDX_EXT_FLAGS && !wdat[`FLG_EXT1] && !ext_ev[1]
		|=> !regs_r.ext_pending_flags[`FLG_EXT1])
		else $error("write of zero did not clear pin 1 flag");

	a_flag_ack_clr: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && ack_in && ack_id_in == `SRC_EXT0 && !ext_ev[0]
		|=> !regs_r.ext_pending_flags[`FLG_EXT0])
		else $error("acknowledge did not clear pin 0 flag");

	a_level_high_det: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && regs_r.ext_pin_enable[0] && !regs_r.ext_dual_edge_enable[0]
		&& !regs_r.ext_edge_select[0] && !regs_r.ext_polarity_select[0] && ext_s2_r[0]
		|=> regs_r.ext_pending_flags[`FLG_EXT0])
		else $error("high level on pin 0 not detected");

	a_fall_edge_det: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && regs_r.ext_pin_enable[1] && !regs_r.ext_dual_edge_enable[1]
		&& regs_r.ext_edge_select[1] && regs_r.ext_polarity_select[1]
		&& $fell(ext_s2_r[1]) |=> regs_r.ext_pending_flags[`FLG_EXT1])
		else $error("falling edge on pin 1 not detected");

	a_dual_no_level: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && regs_r.ext_dual_edge_enable[0] && ext_s2_r[0] == ext_prev_r[0]
		|-> !ext_ev[0])
		else $error("dual edge mode fired on a level");

	a_pin_off_quiet: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!regs_r.ext_pin_enable[1] |-> !ext_ev[1])
		else $error("disabled pin 1 raised an event");

	a_pci_gated: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && regs_r.pin_change_enable == 8'h00
		&& !regs_r.ext_pending_flags[`FLG_PCI] |=> !regs_r.ext_pending_flags[`FLG_PCI])
		else $error("pin change flag set with all pins disabled");

	a_wdt_gated: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && !regs_r.irq_enable_third[`WDT_EN_BIT]
		|=> !(cpu_req_out.valid && cpu_req_out.id == `SRC_WDT))
		else $error("watchdog request passed while disabled");

	a_reset_zero: assert property (@(posedge ref_clk_in)
		sys_rst_in |=> regs_r.prio_low_group1 == `RST_BYTE
		&& regs_r.ext_pending_flags == `RST_BYTE && regs_r.ext_dual_edge_enable == `RST_BYTE)
		else $error("registers not zero after reset");

	a_global_block: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && !regs_r.irq_enable_first[`GIE_BIT] |=> !cpu_req_out.valid)
		else $error("request passed with global enable clear");

	a_top_level_win: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		clk_en_in && elig[0] && prio_of(hi16, lo16, 0) == `LVL_TOP
		|=> cpu_req_out.valid && cpu_req_out.id == `SRC_EXT0 && cpu_req_out.level == `LVL_TOP)
		else $error("source 0 at top level did not win");

endmodule

`default_nettype wire

//--- irq_ctl_defs.svh
// Constants for the interrupt priority and external pin block.
// Assumes register indices are word indices on APB (byte address = 4 x index).
`ifndef IRQ_CTL_DEFS_SVH
`define IRQ_CTL_DEFS_SVH

// Register word indices
`define IDX_PRIO_LO0   10'h092
`define IDX_PRIO_HI0   10'h093
`define IDX_PRIO_LO1   10'h09a
`define IDX_PRIO_HI1   10'h09b
`define IDX_PRIO_LO2   10'h09c
`define IDX_PRIO_HI2   10'h09d
`define IDX_PIN_CHG    10'h09f
`define IDX_EXT_EN     10'h0a3
`define IDX_EXT_FLAGS  10'h0a4
`define IDX_EXT_EDGE   10'h0a5
`define IDX_EXT_POL    10'h0a6
`define IDX_EXT_DUAL   10'h0a7
`define IDX_IE_FIRST   10'h0a8
`define IDX_IE_SECOND  10'h0a9
`define IDX_IE_THIRD   10'h0aa
`define IDX_EVT_STAT   10'h0b0
`define IDX_EVT_MASK   10'h0b1

// Implemented-bit masks
`define MSK_PRIO6      8'h3f
`define MSK_PRIO4      8'h0f
`define MSK_PIN_CHG    8'hff
`define MSK_EXT2       8'h03
`define MSK_FLAGS      8'h0b
`define MSK_IE_FIRST   8'h9b
`define MSK_IE_SECOND  8'h2e
`define MSK_IE_THIRD   8'h07

// Reset value of every register
`define RST_BYTE       8'h00

// Bit positions
`define FLG_EXT0       0
`define FLG_EXT1       1
`define FLG_PCI        3
`define GIE_BIT        7
`define WDT_EN_BIT     0

// Source numbers and the top priority level
`define SRC_EXT0       4'h0
`define SRC_WDT        4'hc
`define LVL_TOP        2'h3

`endif

//--- irq_ctl_pkg.sv
// Types shared by the interrupt priority and external pin block.
// Assumes the constants header is compiled alongside.
package irq_ctl_pkg;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] id;
		logic [1:0] level;
	} cpu_req_t;

	typedef struct packed {
		logic [7:0] prio_low_group0;
		logic [7:0] prio_high_group0;
		logic [7:0] prio_low_group1;
		logic [7:0] prio_high_group1;
		logic [7:0] prio_low_group2;
		logic [7:0] prio_high_group2;
		logic [7:0] pin_change_enable;
		logic [7:0] ext_pin_enable;
		logic [7:0] ext_pending_flags;
		logic [7:0] ext_edge_select;
		logic [7:0] ext_polarity_select;
		logic [7:0] ext_dual_edge_enable;
		logic [7:0] irq_enable_first;
		logic [7:0] irq_enable_second;
		logic [7:0] irq_enable_third;
		logic [7:0] evt_status;
		logic [7:0] evt_mask;
	} regs_t;

endpackage

//--- tb.sv
// Self-checking bench for the interrupt priority and external pin block.
// Assumes the block's APB timing and two-flop pin synchronisers.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                  ref_clk_in, sys_rst_in, clk_en_in, ack_in, ack_on, slow;
	irq_ctl_pkg::apb_req_t apb_in;
	logic                  pready_out, pslverr_out, irq_out, rerr, saw;
	logic [31:0]           prdata_out, rdat;
	logic [1:0]            ext_pin_in;
	logic [7:0]            port1_pin_in, pc, tg;
	logic [15:0]           src_req_in;
	logic [3:0]            ack_id_in;
	irq_ctl_pkg::cpu_req_t cpu_req_out;
	logic [7:0]            sh [256];
	logic [6:0]            e, row;
	int                    mismatches, checks, rnd;
	localparam logic [7:0] rix [15] = '{8'h92, 8'h93, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9f,
		8'ha3, 8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'ha9, 8'haa, 8'hb1};
	localparam logic [7:0] rmsk [15] = '{8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h0f, 8'h0f, 8'hff,
		8'h03, 8'h03, 8'h03, 8'h03, 8'h9b, 8'h2e, 8'h07, 8'h0b};
	// Pin cases: enable, edge, polarity, dual, start level, end level, flag expected
	localparam logic [6:0] rows [9] = '{7'b0000010, 7'b1000011, 7'b1010101, 7'b1000000,
		7'b1100011, 7'b1100100, 7'b1110101, 7'b1110010, 7'b1001110};

	irq_ctl i_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
		.apb_in(apb_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.prdata_out(prdata_out), .ext_pin_in(ext_pin_in), .port1_pin_in(port1_pin_in),
		.src_req_in(src_req_in), .ack_in(ack_in), .ack_id_in(ack_id_in),
		.cpu_req_out(cpu_req_out), .irq_out(irq_out));
	cpu_core_model i_cpu (.clk_in(ref_clk_in), .rst_in(sys_rst_in), .req_in(cpu_req_out),
		.enable_in(ack_on), .slow_in(slow), .ack_out(ack_in), .ack_id_out(ack_id_in));

	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	task automatic close_out();
		if (mismatches == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		apb_in.psel <= 1'b1;
		apb_in.penable <= 1'b0;
		apb_in.pwrite <= wr;
		apb_in.paddr <= {2'h0, idx, 2'h0};
		apb_in.pwdata <= {24'h0, wd};
		@(posedge ref_clk_in);
		apb_in.penable <= 1'b1;
		n = 0;
		// Read before this edge's updates land, so the values are those sampled at it
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		if (pready_out !== 1'b1) begin
			mismatches++;
			close_out();
		end else begin
			rdat = prdata_out;
			rerr = pslverr_out;
			if (wr) sh[idx] = wd;
			apb_in.psel <= 1'b0;
			apb_in.penable <= 1'b0;
			// One idle edge keeps the release apart from the next setup
			@(posedge ref_clk_in);
		end
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask

	// Reference winner: highest level first, then lowest source number
	function automatic logic [6:0] expect_req();
		logic [15:0] en, rq, lo, hi;
		int best, bl;
		en = {sh[8'haa][3:0], sh[8'ha9][5:0], sh[8'ha8][5:0]} & 16'h7b9b;
		lo = {sh[8'h9c][3:0], sh[8'h9a][5:0], sh[8'h92][5:0]};
		hi = {sh[8'h9d][3:0], sh[8'h9b][5:0], sh[8'h93][5:0]};
		rq = src_req_in & 16'hffd4;
		best = -1;
		bl = -1;
		for (int s = 0; s < 16; s++) begin
			if (sh[8'ha8][7] && rq[s] && en[s] && int'({hi[s], lo[s]}) > bl) begin
				best = s;
				bl = int'({hi[s], lo[s]});
			end
		end
		return (best < 0) ? 7'h00 : {1'b1, 4'(best), 2'(bl)};
	endfunction

	always @(posedge ref_clk_in) if (cpu_req_out.valid === 1'b1) saw <= 1'b1;

	initial begin
		mismatches = 0;
		checks = 0;
		sys_rst_in = 1'b1;
		clk_en_in = 1'b1;
		apb_in = '0;
		ext_pin_in = 2'h0;
		port1_pin_in = 8'h00;
		src_req_in = 16'h0000;
		ack_on = 1'b0;
		slow = 1'b0;
		saw = 1'b0;
		foreach (sh[i]) sh[i] = 8'h00;
		rnd = $urandom(32'h8da8);
		wait_clk(16);
		sys_rst_in <= 1'b0;
		wait_clk(1);
		// Reset values, reserved bits, unmapped index
		for (int i = 0; i < 15; i++) begin
			apb(1'b0, rix[i], 8'h00);
			chk("reset value", rdat, 32'h0);
			apb(1'b1, rix[i], 8'hff);
			apb(1'b0, rix[i], 8'h00);
			chk("implemented bits", rdat, {24'h0, rmsk[i]});
			apb(1'b1, rix[i], 8'h00);
		end
		apb(1'b1, 8'ha4, 8'hff);
		apb(1'b0, 8'ha4, 8'h00);
		chk("flags after write one", rdat, 32'h0);
		apb(1'b0, 8'h50, 8'h00);
		chk("unmapped error", {31'h0, rerr}, 32'h1);
		// Random levels, enables and requests against the reference winner
		for (int k = 0; k < 24; k++) begin
			src_req_in <= 16'($urandom()) & 16'hfff4;
			for (int i = 0; i < 6; i++) apb(1'b1, rix[i], 8'($urandom()));
			for (int i = 11; i < 14; i++) apb(1'b1, rix[i], 8'($urandom()));
			wait_clk(3);
			@(negedge ref_clk_in);
			e = expect_req();
			chk("request valid", {31'h0, cpu_req_out.valid}, {31'h0, e[6]});
			if (e[6]) chk("winner", {cpu_req_out.id, cpu_req_out.level}, e[5:0]);
			// Back onto the rising edge before driving again
			wait_clk(1);
		end
		src_req_in <= 16'h0000;
		apb(1'b1, 8'ha8, 8'h00);
		// External pin detection modes on both pins at once
		foreach (rows[r]) begin
			row = rows[r];
			ext_pin_in <= {2{row[2]}};
			apb(1'b1, 8'ha3, {6'h0, {2{row[6]}}});
			apb(1'b1, 8'ha5, {6'h0, {2{row[5]}}});
			apb(1'b1, 8'ha6, {6'h0, {2{row[4]}}});
			apb(1'b1, 8'ha7, {6'h0, {2{row[3]}}});
			wait_clk(4);
			apb(1'b1, 8'ha4, 8'h00);
			ext_pin_in <= {2{row[1]}};
			wait_clk(6);
			apb(1'b0, 8'ha4, 8'h00);
			chk("pin flags", rdat, {30'h0, {2{row[0]}}});
			if (row[0] && (row[5] || row[3])) begin
				apb(1'b1, 8'ha4, 8'h00);
				apb(1'b0, 8'ha4, 8'h00);
				chk("flags cleared by zero", rdat, 32'h0);
			end
		end
		// Rising edges serviced by the core; status and mask drive the interrupt line
		apb(1'b1, 8'ha7, 8'h00);
		apb(1'b1, 8'ha6, 8'h00);
		// Edge mode, so a pin left high cannot re-set a serviced flag
		apb(1'b1, 8'ha5, 8'h03);
		ext_pin_in <= 2'h0;
		wait_clk(4);
		apb(1'b1, 8'ha4, 8'h00);
		apb(1'b1, 8'hb0, 8'hff);
		apb(1'b1, 8'hb1, 8'h0b);
		apb(1'b1, 8'ha8, 8'h83);
		ack_on <= 1'b1;
		slow <= 1'b1;
		saw <= 1'b0;
		ext_pin_in <= 2'h3;
		wait_clk(40);
		apb(1'b0, 8'ha4, 8'h00);
		chk("flags after service", rdat, 32'h0);
		chk("request seen", {31'h0, saw}, 32'h1);
		apb(1'b0, 8'hb0, 8'h00);
		chk("event status", rdat, 32'h3);
		chk("irq line set", {31'h0, irq_out}, 32'h1);
		apb(1'b1, 8'hb0, 8'h03);
		chk("irq line cleared", {31'h0, irq_out}, 32'h0);
		apb(1'b1, 8'hb1, 8'h00);
		apb(1'b1, 8'ha7, 8'h03);
		ext_pin_in <= 2'h0;
		wait_clk(30);
		apb(1'b0, 8'hb0, 8'h00);
		chk("masked status", rdat, 32'h3);
		chk("irq line masked", {31'h0, irq_out}, 32'h0);
		// Pin-change detection against random enables and toggles
		ack_on <= 1'b0;
		apb(1'b1, 8'ha8, 8'h00);
		apb(1'b1, 8'ha3, 8'h00);
		for (int k = 0; k < 10; k++) begin
			pc = 8'($urandom());
			tg = (k == 0) ? 8'h00 : 8'($urandom());
			apb(1'b1, 8'h9f, pc);
			apb(1'b1, 8'ha4, 8'h00);
			port1_pin_in <= port1_pin_in ^ tg;
			wait_clk(6);
			apb(1'b0, 8'ha4, 8'h00);
			chk("pin change flag", rdat, {28'h0, |(pc & tg), 3'h0});
		end
		// Frozen clock enable holds every stage; the change lands once it returns
		apb(1'b1, 8'h9f, 8'hff);
		apb(1'b1, 8'ha4, 8'h00);
		apb(1'b1, 8'ha8, 8'h88);
		clk_en_in <= 1'b0;
		port1_pin_in <= ~port1_pin_in;
		wait_clk(8);
		chk("frozen request", {31'h0, cpu_req_out.valid}, 32'h0);
		clk_en_in <= 1'b1;
		wait_clk(6);
		chk("thawed request", {31'h0, cpu_req_out.valid}, 32'h1);
		close_out();
	end
endmodule
`default_nettype wire
